// ### verilog/cmc_pkg.sv
// constants and types for the CAN mode control register block
`default_nettype none

package cmc_pkg;

  // ------------------------------------------------------------
  // register addresses
  // ------------------------------------------------------------
  localparam logic [15:0] CTRL_ADDR = 16'hff90;
  localparam logic [15:0] INFO_ADDR = 16'hff93;
  localparam logic [15:0] ERC_ADDR = 16'hff94;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [7:0] INFO_RESET = 8'h00;
  localparam logic [15:0] ERC_RESET = 16'h0000;

  // ------------------------------------------------------------
  // field positions, write view
  // ------------------------------------------------------------
  localparam int W_SET_CNT_CLR = 15;
  localparam int W_SET_RETRY = 14;
  localparam int W_SET_PS_HI = 12;
  localparam int W_SET_PS_LO = 11;
  localparam int W_SET_OP_HI = 10;
  localparam int W_SET_OP_LO = 8;
  localparam int W_CLR_CNT_CLR = 7;
  localparam int W_CLR_RETRY = 6;
  localparam int W_CLR_VALID = 5;
  localparam int W_CLR_PS_HI = 4;
  localparam int W_CLR_PS_LO = 3;
  localparam int W_CLR_OP_HI = 2;
  localparam int W_CLR_OP_LO = 0;

  // ------------------------------------------------------------
  // error counter steps and thresholds
  // ------------------------------------------------------------
  localparam logic [8:0] TEC_STEP_ERR = 9'h008;
  localparam logic [7:0] REC_STEP_ERR = 8'h08;
  localparam logic [8:0] WARN_LEVEL = 9'h060;
  localparam logic [8:0] PASSIVE_LEVEL = 9'h080;
  localparam logic [8:0] BUS_OFF_LEVEL = 9'h100;
  localparam logic [7:0] REC_MAX = 8'hff;

  // ------------------------------------------------------------
  // mode encodings
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_INIT = 3'h0,
    OP_NORMAL = 3'h1,
    OP_NORMAL_BLOCK = 3'h2,
    OP_RX_ONLY = 3'h3,
    OP_SINGLE_SHOT = 3'h4,
    OP_SELF_TEST = 3'h5
  } cmc_op_t;

  localparam logic [2:0] OP_LAST = 3'h5;

  typedef enum logic [1:0] {
    PS_NONE = 2'h0,
    PS_SLEEP = 2'h1,
    PS_BAD = 2'h2,
    PS_STOP = 2'h3
  } cmc_ps_t;

endpackage

`default_nettype wire

// ### verilog/cmc_mode_control.sv
// CAN module mode control register with activity flags and error counters
`default_nettype none

// Function
// - 16-bit mode control register at FF90H, reset zero, software read/write.
// - mode bits: set=1 clear=0 sets, set=0 clear=1 clears, else unchanged.
// - counter-clear bit set only when bits 15 and 7 both written one.
// - writing one at bit 5 clears valid-frame flag; zero leaves it.
// - receive activity set by receive start-of-frame or arbitration loss.
// - receive activity cleared by recessive second gap bit or init at first.
// - transmit activity set by transmit start-of-frame or first error-flag bit.
// - transmit activity cleared by bus-off, arbitration loss, recessive second gap bit, init entry.
// - counter-clear bit one clears error counter and information registers.
// - counter-clear accepted only in init, including the write leaving init.
// - counter-clear bit drops to zero by itself after clearing.
// - counter-clear bit read-only in sleep or stop.
// - arbitration-loss retry bit only matters in single-shot mode.
// - valid-frame flag set by any valid received frame.
// - receive-only mode never drives an acknowledge bit.
// - power-save codes: 00 none, 01 sleep, 11 stop, 10 refused.
// - stop mode entered and left only through sleep mode.
// - sleep request pending until cancelled or bus idle; read shows actual.
// - operation codes 000 to 101 as listed; others refused.
// - operation field read-only in sleep or stop.
// - separate error counter register holds transmit and receive counts.

module cmc_mode_control (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // register port
  input wire logic [15:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WRITE,
  input wire logic REG_READ,
  output logic [15:0] REG_RDATA,
  // frame events from the protocol engine
  input wire logic RX_SOF,
  input wire logic TX_SOF,
  input wire logic ARB_LOST,
  input wire logic TX_ERROR_FLAG_FIRST,
  input wire logic IFS_FIRST_BIT,
  input wire logic IFS_SECOND_RECESSIVE,
  input wire logic VALID_FRAME,
  input wire logic BUS_IDLE,
  // error counting events
  input wire logic TX_ERROR,
  input wire logic TX_SUCCESS,
  input wire logic RX_ERROR,
  input wire logic RX_ERROR_SEVERE,
  input wire logic RX_SUCCESS,
  // mode outputs
  output logic [2:0] OPERATION_MODE,
  output logic [1:0] POWER_SAVE,
  output logic SLEEP_PENDING,
  output logic RETRY_ON_ARB_LOSS,
  output logic ACK_PERMIT,
  output logic BUS_OFF
);

  // ------------------------------------------------------------
  // set/clear pair update
  // ------------------------------------------------------------
  function automatic logic [2:0] pair_update(input logic [2:0] cur, input logic [2:0] s,
                                             input logic [2:0] c);
    logic [2:0] r;
    r = cur;
    for (int i = 0; i < 3; i++) begin
      if (s[i] && !c[i]) begin
        r[i] = 1'b1;
      end else if (!s[i] && c[i]) begin
        r[i] = 1'b0;
      end
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  cmc_pkg::cmc_op_t op_mode;
  cmc_pkg::cmc_ps_t ps_mode;
  logic init_pending;
  logic sleep_pending;
  logic error_counter_clear_bit;
  logic retry_on_lost_arbitration;
  logic valid;
  logic receive_activity_flag;
  logic transmit_activity_flag;
  logic [8:0] tec;
  logic [7:0] rec;

  // ------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------
  logic ctrl_wr;
  logic in_power_save;
  logic busy;
  logic [2:0] op_target;
  logic [2:0] ps_wide;
  logic [1:0] ps_target;
  logic op_wr_ok;
  logic leave_req;
  logic init_req;
  logic init_enter;
  logic init_at_gap;
  logic cnt_clr_set;
  logic clear_counters;

  assign ctrl_wr = REG_WRITE && (REG_ADDR == cmc_pkg::CTRL_ADDR);
  assign in_power_save = (ps_mode != cmc_pkg::PS_NONE);
  assign busy = receive_activity_flag || transmit_activity_flag;

  // bit 13 is not part of any pair and is never looked at
  assign op_target = pair_update(op_mode,
                                 REG_WDATA[cmc_pkg::W_SET_OP_HI:cmc_pkg::W_SET_OP_LO],
                                 REG_WDATA[cmc_pkg::W_CLR_OP_HI:cmc_pkg::W_CLR_OP_LO]);
  assign ps_wide = pair_update({1'b0, ps_mode},
                               {1'b0, REG_WDATA[cmc_pkg::W_SET_PS_HI:cmc_pkg::W_SET_PS_LO]},
                               {1'b0, REG_WDATA[cmc_pkg::W_CLR_PS_HI:cmc_pkg::W_CLR_PS_LO]});
  assign ps_target = ps_wide[1:0];

  // operation field frozen in power save, prohibited codes refused
  assign op_wr_ok = ctrl_wr && !in_power_save && (op_target <= cmc_pkg::OP_LAST);
  assign leave_req = op_wr_ok && (op_target != 3'h0);
  assign init_req = op_wr_ok && (op_target == 3'h0) && (op_mode != cmc_pkg::OP_INIT);

  // init taken at once when idle, else at the first gap bit
  assign init_enter = (init_pending || init_req) && !leave_req && (IFS_FIRST_BIT || !busy);
  assign init_at_gap = init_enter && IFS_FIRST_BIT && !in_power_save;

  // ------------------------------------------------------------
  // operation mode
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      op_mode <= cmc_pkg::OP_INIT;
      init_pending <= 1'b0;
    end else if (leave_req) begin
      op_mode <= cmc_pkg::cmc_op_t'(op_target);
      init_pending <= 1'b0;
    end else if (init_enter && !in_power_save) begin
      op_mode <= cmc_pkg::OP_INIT;
      init_pending <= 1'b0;
    end else if (init_req) begin
      init_pending <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // power save
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      ps_mode <= cmc_pkg::PS_NONE;
      sleep_pending <= 1'b0;
    end else if (ctrl_wr && (ps_target != 2'h2)) begin
      case (ps_mode)
        cmc_pkg::PS_NONE: begin
          // sleep waits for an idle bus, stop cannot be reached from here
          if (ps_target == 2'h1) begin
            if (BUS_IDLE) begin
              ps_mode <= cmc_pkg::PS_SLEEP;
              sleep_pending <= 1'b0;
            end else begin
              sleep_pending <= 1'b1;
            end
          end else if (ps_target == 2'h0) begin
            sleep_pending <= 1'b0;
          end
        end
        cmc_pkg::PS_SLEEP: begin
          if (ps_target == 2'h0) begin
            ps_mode <= cmc_pkg::PS_NONE;
          end else if (ps_target == 2'h3) begin
            ps_mode <= cmc_pkg::PS_STOP;
          end
        end
        cmc_pkg::PS_STOP: begin
          if (ps_target == 2'h1) begin
            ps_mode <= cmc_pkg::PS_SLEEP;
          end
        end
        default: begin
          ps_mode <= cmc_pkg::PS_NONE;
        end
      endcase
    end else if (sleep_pending && BUS_IDLE) begin
      ps_mode <= cmc_pkg::PS_SLEEP;
      sleep_pending <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // error counter clear bit
  // ------------------------------------------------------------
  // op_mode is still init during the write that leaves init
  assign cnt_clr_set = ctrl_wr && REG_WDATA[cmc_pkg::W_SET_CNT_CLR] &&
                       REG_WDATA[cmc_pkg::W_CLR_CNT_CLR] && !in_power_save &&
                       (op_mode == cmc_pkg::OP_INIT);
  assign clear_counters = error_counter_clear_bit;

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      error_counter_clear_bit <= 1'b0;
    end else if (cnt_clr_set) begin
      error_counter_clear_bit <= 1'b1;
    end else if (clear_counters) begin
      error_counter_clear_bit <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // arbitration loss retry bit
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      retry_on_lost_arbitration <= 1'b0;
    end else if (ctrl_wr) begin
      if (REG_WDATA[cmc_pkg::W_SET_RETRY] && !REG_WDATA[cmc_pkg::W_CLR_RETRY]) begin
        retry_on_lost_arbitration <= 1'b1;
      end else if (!REG_WDATA[cmc_pkg::W_SET_RETRY] && REG_WDATA[cmc_pkg::W_CLR_RETRY]) begin
        retry_on_lost_arbitration <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // valid frame flag
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      valid <= 1'b0;
    end else if (VALID_FRAME) begin
      valid <= 1'b1;
    end else if (ctrl_wr && REG_WDATA[cmc_pkg::W_CLR_VALID]) begin
      valid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // error counters
  // ------------------------------------------------------------
  logic [8:0] next_tec;
  logic [7:0] next_rec;
  logic bus_off;
  logic enter_bus_off;

  assign bus_off = (tec >= cmc_pkg::BUS_OFF_LEVEL);

  always_comb begin
    next_tec = tec;
    if (TX_ERROR && !bus_off) begin
      next_tec = tec + cmc_pkg::TEC_STEP_ERR;
    end else if (TX_SUCCESS && (tec != 9'h000) && !bus_off) begin
      next_tec = tec - 9'h001;
    end
  end

  always_comb begin
    next_rec = rec;
    if (RX_ERROR_SEVERE) begin
      if (rec > (cmc_pkg::REC_MAX - cmc_pkg::REC_STEP_ERR)) begin
        next_rec = cmc_pkg::REC_MAX;
      end else begin
        next_rec = rec + cmc_pkg::REC_STEP_ERR;
      end
    end else if (RX_ERROR) begin
      if (rec != cmc_pkg::REC_MAX) begin
        next_rec = rec + 8'h01;
      end
    end else if (RX_SUCCESS && (rec != 8'h00)) begin
      next_rec = rec - 8'h01;
    end
  end

  assign enter_bus_off = !bus_off && (next_tec >= cmc_pkg::BUS_OFF_LEVEL);

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      tec <= 9'h000;
      rec <= 8'h00;
    end else if (clear_counters) begin
      tec <= 9'h000;
      rec <= 8'h00;
    end else begin
      tec <= next_tec;
      rec <= next_rec;
    end
  end

  // ------------------------------------------------------------
  // activity flags
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      receive_activity_flag <= 1'b0;
    end else if (RX_SOF || ARB_LOST) begin
      receive_activity_flag <= 1'b1;
    end else if (IFS_SECOND_RECESSIVE || init_at_gap) begin
      receive_activity_flag <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      transmit_activity_flag <= 1'b0;
    end else if (TX_SOF || TX_ERROR_FLAG_FIRST) begin
      transmit_activity_flag <= 1'b1;
    end else if (enter_bus_off || ARB_LOST || IFS_SECOND_RECESSIVE || init_at_gap) begin
      transmit_activity_flag <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // register views
  // ------------------------------------------------------------
  logic [15:0] ctrl_view;
  logic [7:0] info_view;
  logic [15:0] erc_view;
  logic [1:0] tec_state;
  logic [1:0] rec_state;

  always_comb begin
    if (tec >= cmc_pkg::PASSIVE_LEVEL) begin
      tec_state = 2'h3;
    end else if (tec >= cmc_pkg::WARN_LEVEL) begin
      tec_state = 2'h1;
    end else begin
      tec_state = 2'h0;
    end
  end

  always_comb begin
    if ({1'b0, rec} >= cmc_pkg::PASSIVE_LEVEL) begin
      rec_state = 2'h3;
    end else if ({1'b0, rec} >= cmc_pkg::WARN_LEVEL) begin
      rec_state = 2'h1;
    end else begin
      rec_state = 2'h0;
    end
  end

  assign ctrl_view = {6'h00, receive_activity_flag, transmit_activity_flag,
                      error_counter_clear_bit, retry_on_lost_arbitration, valid, ps_mode, op_mode};
  assign info_view = {3'h0, bus_off, tec_state, rec_state};
  assign erc_view = {rec_state[1], rec[6:0], tec[7:0]};

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      REG_RDATA <= 16'h0000;
    end else if (REG_READ) begin
      if (REG_ADDR == cmc_pkg::CTRL_ADDR) begin
        REG_RDATA <= ctrl_view;
      end else if (REG_ADDR == cmc_pkg::INFO_ADDR) begin
        REG_RDATA <= {8'h00, info_view};
      end else if (REG_ADDR == cmc_pkg::ERC_ADDR) begin
        REG_RDATA <= erc_view;
      end else begin
        REG_RDATA <= 16'h0000;
      end
    end else begin
      REG_RDATA <= 16'h0000;
    end
  end

  // ------------------------------------------------------------
  // mode outputs
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      OPERATION_MODE <= 3'h0;
      POWER_SAVE <= 2'h0;
      SLEEP_PENDING <= 1'b0;
      BUS_OFF <= 1'b0;
      RETRY_ON_ARB_LOSS <= 1'b1;
      ACK_PERMIT <= 1'b0;
    end else begin
      OPERATION_MODE <= op_mode;
      POWER_SAVE <= ps_mode;
      SLEEP_PENDING <= sleep_pending;
      BUS_OFF <= bus_off;
      RETRY_ON_ARB_LOSS <= (op_mode != cmc_pkg::OP_SINGLE_SHOT) ||
                           retry_on_lost_arbitration;
      // acknowledge only in a live mode other than receive-only
      ACK_PERMIT <= (op_mode != cmc_pkg::OP_INIT) && (op_mode != cmc_pkg::OP_RX_ONLY) &&
                    !in_power_save;
    end
  end

endmodule

`default_nettype wire

// ### tb/cmc_props.sv
// concurrent checks on the mode control register ports
`default_nettype none

module cmc_props (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // register port
  input wire logic [15:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WRITE,
  input wire logic REG_READ,
  input wire logic [15:0] REG_RDATA,
  // bus state and modes
  input wire logic BUS_IDLE,
  input wire logic [2:0] OPERATION_MODE,
  input wire logic [1:0] POWER_SAVE,
  input wire logic SLEEP_PENDING,
  input wire logic RETRY_ON_ARB_LOSS,
  input wire logic ACK_PERMIT
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);

  // ------------------------------------------------------------
  // sequences
  // ------------------------------------------------------------
  sequence ctrl_rd;
    REG_READ && REG_ADDR == cmc_pkg::CTRL_ADDR;
  endsequence

  sequence to_normal;
    REG_WRITE && REG_ADDR == cmc_pkg::CTRL_ADDR && REG_WDATA == 16'h0106 &&
      POWER_SAVE == 2'h0 && !SLEEP_PENDING && !$past(REG_WRITE);
  endsequence

  sequence wake;
    SLEEP_PENDING && BUS_IDLE;
  endsequence

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  rd_idle_zero_a: assert property (!REG_READ |=> REG_RDATA == 16'h0000)
    else $error("read data not zero outside read answer");
  rd_unused_a: assert property (ctrl_rd |=> REG_RDATA[15:10] == 6'h00)
    else $error("unused control bits not zero");
  ps_legal_a: assert property (POWER_SAVE != 2'h2)
    else $error("prohibited power save code");
  op_legal_a: assert property (OPERATION_MODE <= 3'h5)
    else $error("prohibited operation code");
  stop_via_sleep_a: assert property ($changed(POWER_SAVE) && POWER_SAVE != 2'h1 |->
    $past(POWER_SAVE) == 2'h1)
    else $error("stop entered or left directly");
  op_frozen_a: assert property (POWER_SAVE != 2'h0 && $past(POWER_SAVE) != 2'h0 |->
    $stable(OPERATION_MODE))
    else $error("operation mode changed in power save");
  ack_rx_only_a: assert property (OPERATION_MODE == 3'h3 |-> !ACK_PERMIT)
    else $error("acknowledge permitted in receive-only");
  retry_mode_a: assert property (OPERATION_MODE != 3'h4 |-> RETRY_ON_ARB_LOSS)
    else $error("retry suppressed outside single-shot");
  set_mode_a: assert property (to_normal |=> ##1 OPERATION_MODE == 3'h1)
    else $error("set/clear pair did not select normal");
  sleep_wake_a: assert property (wake |-> ##[1:3] (POWER_SAVE == 2'h1 || !SLEEP_PENDING))
    else $error("pending sleep not entered on idle bus");
endmodule

bind cmc_mode_control cmc_props u_props (.*);

`default_nettype wire

// ### tb/cmc_bus_node.sv
// other nodes on the bus: produce frame events toward the controller
`default_nettype none

module cmc_bus_node (
  // clock
  input wire logic CLOCK,
  // frame events
  output logic RX_SOF,
  output logic TX_SOF,
  output logic ARB_LOST,
  output logic TX_ERROR_FLAG_FIRST,
  output logic IFS_FIRST_BIT,
  output logic IFS_SECOND_RECESSIVE,
  output logic VALID_FRAME,
  output logic BUS_IDLE
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    {RX_SOF, TX_SOF, ARB_LOST, TX_ERROR_FLAG_FIRST} = 4'h0;
    {IFS_FIRST_BIT, IFS_SECOND_RECESSIVE, VALID_FRAME} = 3'h0;
    BUS_IDLE = 1'b1;
  end

  // kind 0 receive, 1 transmit, 2 transmit losing arbitration
  task automatic frame(input int kind, input int len);
    @(posedge CLOCK);
    BUS_IDLE <= 1'b0;
    RX_SOF <= (kind == 0);
    TX_SOF <= (kind != 0);
    @(posedge CLOCK);
    RX_SOF <= 1'b0;
    TX_SOF <= 1'b0;
    ARB_LOST <= (kind == 2);
    @(posedge CLOCK);
    ARB_LOST <= 1'b0;
    repeat (len) @(posedge CLOCK);
    VALID_FRAME <= (kind != 1);
    @(posedge CLOCK);
    VALID_FRAME <= 1'b0;
    IFS_FIRST_BIT <= 1'b1;
    @(posedge CLOCK);
    IFS_FIRST_BIT <= 1'b0;
    IFS_SECOND_RECESSIVE <= 1'b1;
    @(posedge CLOCK);
    IFS_SECOND_RECESSIVE <= 1'b0;
    BUS_IDLE <= 1'b1;
  endtask
endmodule

`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the mode control register
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [15:0] C = cmc_pkg::CTRL_ADDR;
  localparam logic [15:0] E = cmc_pkg::ERC_ADDR;
  logic CLOCK, RESET, REG_WRITE, REG_READ, rd_d;
  logic [15:0] REG_ADDR, REG_WDATA, REG_RDATA, exp_v;
  logic RX_SOF, TX_SOF, ARB_LOST, TX_ERROR_FLAG_FIRST, IFS_FIRST_BIT;
  logic IFS_SECOND_RECESSIVE, VALID_FRAME, BUS_IDLE;
  logic TX_ERROR, TX_SUCCESS, RX_ERROR, RX_ERROR_SEVERE, RX_SUCCESS;
  logic [2:0] OPERATION_MODE;
  logic [1:0] POWER_SAVE;
  logic SLEEP_PENDING, RETRY_ON_ARB_LOSS, ACK_PERMIT, BUS_OFF;
  logic [15:0] exp_q[$];
  logic [7:0] lfsr, n;
  int num_errors, samples_checked, cyc;

  cmc_mode_control DUT (.*);
  cmc_bus_node node (.*);

  initial begin
    CLOCK = 1'b0;
    forever #50 CLOCK = ~CLOCK;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // w=1 writes d, w=0 reads and notes d as expected
  task acc(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge CLOCK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WRITE <= w;
    REG_READ <= !w;
    if (!w) exp_q.push_back(d);
    @(posedge CLOCK);
    REG_WRITE <= 1'b0;
    REG_READ <= 1'b0;
  endtask

  task pulse_tx(input int k);
    @(posedge CLOCK);
    TX_ERROR <= 1'b1;
    repeat (k) @(posedge CLOCK);
    TX_ERROR <= 1'b0;
  endtask

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task final_report;
    if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge CLOCK) rd_d <= REG_READ;
  always @(negedge CLOCK) begin
    if (rd_d === 1'b1) begin
      exp_v = exp_q.pop_front();
      chk(REG_RDATA, exp_v);
    end
  end

  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      final_report();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {RESET, REG_WRITE, REG_READ, rd_d} = 4'h8;
    {REG_ADDR, REG_WDATA} = 32'h0;
    {TX_ERROR, TX_SUCCESS, RX_ERROR, RX_ERROR_SEVERE, RX_SUCCESS} = 5'h00;
    lfsr = 8'h50;
    repeat (20) @(posedge CLOCK);
    RESET <= 1'b0;
    acc(0, C, 16'h0000);
    acc(0, 16'hff92, 16'h0000);
    acc(1, C, 16'h2000);
    acc(0, C, 16'h0000);
    for (int c = 1; c < 6; c++) begin
      acc(1, C, {5'h00, 3'(c), 5'h00, ~3'(c)});
      acc(0, C, {13'h0000, 3'(c)});
      chk({15'h0, ACK_PERMIT}, {15'h0, c != 3});
      if (c == 4) begin
        repeat (2) @(negedge CLOCK);
        chk({15'h0, RETRY_ON_ARB_LOSS}, 16'h0000);
        acc(1, C, 16'h4000);
        acc(0, C, 16'h0044);
        chk({15'h0, RETRY_ON_ARB_LOSS}, 16'h0001);
        acc(1, C, 16'h0040);
      end
    end
    acc(1, C, 16'h0601);
    acc(1, C, 16'h0707);
    acc(0, C, 16'h0005);
    acc(1, C, 16'h0106);
    acc(0, C, 16'h0001);
    fork
      node.frame(0, 12);
      begin repeat (5) @(posedge CLOCK); acc(0, C, 16'h0201); end
    join
    acc(0, C, 16'h0021);
    fork
      node.frame(1, 12);
      begin repeat (5) @(posedge CLOCK); acc(0, C, 16'h0121); end
    join
    acc(0, C, 16'h0021);
    fork
      node.frame(2, 12);
      begin repeat (6) @(posedge CLOCK); acc(0, C, 16'h0221); end
    join
    fork
      node.frame(0, 12);
      begin repeat (5) @(posedge CLOCK); acc(1, C, 16'h0001); acc(0, C, 16'h0221); end
    join
    acc(0, C, 16'h0020);
    acc(1, C, 16'h0020);
    acc(0, C, 16'h0000);
    acc(1, C, 16'h0100);
    lfsr = lfsr_next(lfsr);
    n = (lfsr % 8'h07) + 8'h01;
    @(posedge CLOCK);
    RX_ERROR_SEVERE <= 1'b1;
    repeat (n) @(posedge CLOCK);
    RX_ERROR_SEVERE <= 1'b0;
    RX_ERROR <= 1'b1;
    @(posedge CLOCK);
    RX_ERROR <= 1'b0;
    RX_SUCCESS <= 1'b1;
    @(posedge CLOCK);
    RX_SUCCESS <= 1'b0;
    fork
      node.frame(1, 50);
      begin repeat (3) @(posedge CLOCK); pulse_tx(32); acc(0, C, 16'h0001); end
    join
    chk({15'h0, BUS_OFF}, 16'h0001);
    acc(0, E, {1'b0, 7'(n * 8'h08), 8'h00});
    acc(0, cmc_pkg::INFO_ADDR, 16'h001c);
    acc(1, C, 16'h8080);
    acc(0, C, 16'h0001);
    acc(0, E, {1'b0, 7'(n * 8'h08), 8'h00});
    acc(1, C, 16'h0001);
    acc(1, C, 16'h8080);
    acc(0, E, 16'h0000);
    acc(0, C, 16'h0000);
    chk({15'h0, BUS_OFF}, 16'h0000);
    acc(1, C, 16'h0800);
    acc(0, C, 16'h0008);
    acc(1, C, 16'h0100);
    acc(1, C, 16'h8080);
    acc(0, C, 16'h0008);
    acc(1, C, 16'h1000);
    acc(0, C, 16'h0018);
    acc(1, C, 16'h0018);
    acc(0, C, 16'h0018);
    acc(1, C, 16'h0010);
    acc(0, C, 16'h0008);
    acc(1, C, 16'h0008);
    acc(1, C, 16'h1000);
    acc(0, C, 16'h0000);
    acc(1, C, 16'h1800);
    acc(0, C, 16'h0000);
    fork
      node.frame(1, 20);
      begin repeat (4) @(posedge CLOCK); acc(1, C, 16'h0800); end
    join_any
    repeat (3) @(negedge CLOCK);
    chk({14'h0, POWER_SAVE, SLEEP_PENDING}, 16'h0001);
    wait fork;
    repeat (4) @(negedge CLOCK);
    chk({14'h0, POWER_SAVE, SLEEP_PENDING}, 16'h0002);
    acc(0, C, 16'h0008);
    repeat (3) @(posedge CLOCK);
    final_report();
  end
endmodule

`default_nettype wire
